// *** dv/bord_decoder_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module bord_decoder_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Fetch stream
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_byte,
  input wire logic fetch_ready,
  // Decoded operation
  input wire logic op_valid,
  input wire logic op_ready,
  input wire logic [3:0] op_dst_space,
  input wire logic [7:0] op_dst_sel,
  input wire logic [3:0] op_src_space,
  input wire logic [7:0] op_src_sel,
  input wire logic op_dst_write,
  input wire logic op_src_write,
  input wire logic [2:0] op_length,
  input wire logic op_illegal
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  wire logic v = op_valid && !op_illegal;
  property p_rr;
    v && op_src_space == bord_pkg::BORD_SP_BASE_REG && op_dst_space == bord_pkg::BORD_SP_BASE_REG
      |-> op_length == 3'h2 && op_src_sel < 8'h08;
  endproperty
  a_rr: assert property (p_rr) else $error("register pair shape wrong");
  property p_ext;
    v && op_src_space == bord_pkg::BORD_SP_EXT_REG |-> op_length == 3'h3 && op_src_sel < 8'h08;
  endproperty
  a_ext: assert property (p_ext) else $error("extended register shape wrong");
  property p_ptr;
    v && (op_src_space == bord_pkg::BORD_SP_PTR24_SDA || op_dst_space == bord_pkg::BORD_SP_PTR16_SDA
      || op_src_space == bord_pkg::BORD_SP_PTR16_SDA || op_dst_space == bord_pkg::BORD_SP_PTR24_SDA)
      |-> op_length == 3'h4;
  endproperty
  a_ptr: assert property (p_ptr) else $error("alternate pointer length wrong");
  property p_wr;
    op_valid |-> op_dst_write != op_illegal && !op_src_write;
  endproperty
  a_wr: assert property (p_wr) else $error("write target wrong");
  property p_ill;
    op_valid && op_illegal |-> op_length == 3'h1;
  endproperty
  a_ill: assert property (p_ill) else $error("illegal length wrong");
  property p_hold;
    op_valid && !op_ready |=> op_valid && $stable(op_length) && $stable(op_src_sel);
  endproperty
  a_hold: assert property (p_hold) else $error("operation dropped");
  property p_busy;
    op_valid |-> !fetch_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("fetch taken while busy");
  property p_ans;
    $rose(op_valid) |-> $past(fetch_valid && fetch_ready);
  endproperty
  a_ans: assert property (p_ans) else $error("result without byte");
  c_ill: cover property (op_valid && op_illegal);
  c_ext: cover property (v && op_src_space == bord_pkg::BORD_SP_EXT_REG);
  c_stall: cover property (op_valid && !op_ready ##1 op_ready);
  c_ptr_alt: cover property (v && op_dst_space == bord_pkg::BORD_SP_PTR16_SDA);
endmodule
`default_nettype wire

// *** dv/bord_fetch_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bord_fetch_model (
  // Clock
  input wire logic clk_sys,
  // Byte stream
  input wire logic fetch_ready,
  output logic fetch_valid,
  output logic [7:0] fetch_byte
);
  logic [7:0] q[$];
  logic tk;
  initial
  begin
    fetch_valid = 1'b0;
    fetch_byte = 8'h00;
  end
  // Offer held until taken; idle bus inverts the last byte again on every idle cycle
  always @(posedge clk_sys)
  begin
    tk = fetch_valid && fetch_ready;
    #1;
    if (tk || !fetch_valid)
    begin
      if (tk)
        void'(q.pop_front());
      fetch_valid = q.size() != 0 && $urandom_range(3) != 0;
      fetch_byte = fetch_valid ? q[0] : ~fetch_byte;
    end
  end
endmodule
`default_nettype wire

// *** dv/byte_or_operand_decoder_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module byte_or_operand_decoder_tb_top;
  // ----------------
  // Signals
  // ----------------
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic op_ready = 1'b0;
  wire logic fetch_valid, fetch_ready, op_valid, op_dst_write, op_src_write, op_illegal;
  wire logic [7:0] fetch_byte, op_dst_sel, op_src_sel;
  wire logic [3:0] op_dst_space, op_src_space;
  wire logic [2:0] op_length;
  logic [29:0] expq[$];
  logic [29:0] g;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  always #50 clk_sys = ~clk_sys;
  bord_decoder i_bord_decoder (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte),
    .fetch_ready(fetch_ready),
    .op_valid(op_valid),
    .op_ready(op_ready),
    .op_dst_space(op_dst_space),
    .op_dst_sel(op_dst_sel),
    .op_src_space(op_src_space),
    .op_src_sel(op_src_sel),
    .op_dst_write(op_dst_write),
    .op_src_write(op_src_write),
    .op_length(op_length),
    .op_illegal(op_illegal)
  );
  bord_fetch_model i_bord_fetch_model (
    .clk_sys(clk_sys),
    .fetch_ready(fetch_ready),
    .fetch_valid(fetch_valid),
    .fetch_byte(fetch_byte)
  );
  // ----------------
  // Helpers
  // ----------------
  function automatic logic [29:0] ex(input logic [3:0] ds, input logic [7:0] dl,
      input logic [3:0] ss, input logic [7:0] sl, input logic [2:0] n);
    ex = {2'b10, ds, dl, ss, sl, n, 1'b0};
  endfunction
  task automatic send(input logic [7:0] b[$], input logic [29:0] e);
    expq.push_back(e);
    foreach (b[i])
      i_bord_fetch_model.q.push_back(b[i]);
  endtask
  task automatic check(input logic [29:0] got, input logic [29:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------
  // Execute side and checking
  // ----------------
  // Random back-pressure keeps results standing across several cycles
  always @(posedge clk_sys)
    op_ready <= #1 ($urandom_range(2) != 0);
  // Sampled mid-cycle, the values that the next rising edge accepts
  always @(negedge clk_sys)
    if (rst_n && op_valid && op_ready)
    begin
      g = {op_dst_write, op_src_write, op_dst_space,
        op_dst_space == bord_pkg::BORD_SP_ACC ? 8'h00 : op_dst_sel, op_src_space,
        op_src_space == bord_pkg::BORD_SP_ACC ? 8'h00 : op_src_sel, op_length, op_illegal};
      check(op_illegal ? {26'h0, op_length, 1'b1} : g, expq.pop_front());
    end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      complete_run();
    end
  end
  initial
  begin
    logic [7:0] r, s, d;
    logic [7:0] b[$];
    logic [3:0] sp;
    void'($urandom(488));
    repeat (4) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (12)
    begin
      r = $urandom;
      s = $urandom;
      d = $urandom;
      r[3] = 1'b0;
      sp = bord_pkg::BORD_SP_BASE_REG;
      send('{8'h8E, r}, ex(sp, r >> 4, sp, {5'h0, r[2:0]}, 3'h2));
      send('{8'h3C, 8'h8E, r},
        ex(sp, r >> 4, bord_pkg::BORD_SP_EXT_REG, {5'h0, r[2:0]}, 3'h3));
      send('{8'h9E, s}, ex(bord_pkg::BORD_SP_ACC, 8'h00, bord_pkg::BORD_SP_SDP, s, 3'h2));
      for (int k = 0; k < 7; k++)
      begin
        sp = bord_pkg::BORD_SP_SDP + k[1:0];
        if (k < 3)
          send('{8'h7E, {r[7:4], 4'(k)}, s}, ex(1, r >> 4, sp, s, 3'h3));
        else if (k > 3)
          send('{8'h7E, {r[7:4], 4'(k)}, s}, ex(sp, s, 1, r >> 4, 3'h3));
      end
      sp = bord_pkg::BORD_SP_SDP;
      for (int k = 0; k < 4; k++)
        send('{8'h2A, {4'(k), 4'hE}, s, d},
          ex(sp + k[1], d, sp + k[0], s, 3'h4));
      for (int k = 0; k < 8; k++)
      begin
        sp = bord_pkg::BORD_SP_PTR16_SDP + 2 * k[0] + k[2];
        b = {};
        if (k[2])
          b.push_back(8'h3C);
        b.push_back(8'h07);
        b.push_back({k[1], 2'b01, k[0], 4'hE});
        b.push_back(s);
        if (k[1])
          send(b, ex(sp, s, bord_pkg::BORD_SP_ACC, 8'h00, 3'h3 + k[2]));
        else
          send(b, ex(bord_pkg::BORD_SP_ACC, 8'h00, sp, s, 3'h3 + k[2]));
      end
      send('{8'hFF}, 30'h3);
    end
    wait (expq.size() == 0);
    repeat (4) @(posedge clk_sys);
    complete_run();
  end
endmodule
bind bord_decoder bord_decoder_props i_props (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .fetch_valid(fetch_valid),
  .fetch_byte(fetch_byte),
  .fetch_ready(fetch_ready),
  .op_valid(op_valid),
  .op_ready(op_ready),
  .op_dst_space(op_dst_space),
  .op_dst_sel(op_dst_sel),
  .op_src_space(op_src_space),
  .op_src_sel(op_src_sel),
  .op_dst_write(op_dst_write),
  .op_src_write(op_src_write),
  .op_length(op_length),
  .op_illegal(op_illegal)
);
`default_nettype wire

// *** hw/bord_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RQ1 - 8E then byte: dest reg bits 7..4, source base reg bits 2..0
// RQ2 - Prefix 3C before 8E takes source from extended register set
// RQ3 - 9E with offset byte ORs primary short direct into accumulator
// RQ4 - 7E, nibble 0: primary short direct into selected register
// RQ5 - 7E, nibble 1: alternate short direct into selected register
// RQ6 - 7E, nibble 4: register into primary short direct location
// RQ7 - 7E, nibble 5: register into alternate short direct location
// RQ8 - 7E, nibble 2: special function register into selected register
// RQ9 - 7E, nibble 6: register into special function register
// RQ10 - 2A 0E: primary source byte three into primary destination byte four
// RQ11 - 2A 1E: alternate source into primary destination
// RQ12 - 2A 2E: primary source into alternate destination
// RQ13 - 2A 3E: alternate source into alternate destination
// RQ14 - 07 2E: accumulator OR memory via 16-bit primary pointer
// RQ15 - 07 3E: accumulator OR memory via 24-bit primary pointer
// RQ16 - 07 AE/BE: accumulator ORed into memory via 16/24-bit pointer
// RQ17 - Prefix 3C makes pointer alternate, offset from fourth byte
// RQ18 - 3C 07 AE: accumulator into memory via alternate 16-bit pointer
// RQ19 - Result goes to first operand; second operand unchanged
// RQ20 - Consume full form length including prefix and offsets
module bord_decoder (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Fetch stream
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_byte,
  output logic fetch_ready,
  // Decoded operation to execute stage
  output logic op_valid,
  input wire logic op_ready,
  output logic [3:0] op_dst_space,
  output logic [7:0] op_dst_sel,
  output logic [3:0] op_src_space,
  output logic [7:0] op_src_sel,
  output logic op_dst_write,
  output logic op_src_write,
  output logic [2:0] op_length,
  output logic op_illegal
);

  typedef enum logic [1:0] {
    BORD_ST_COLLECT = 2'b00,
    BORD_ST_ISSUE = 2'b01
  } bord_state_t;

  // ----------------------------------------
  // Byte collection
  // ----------------------------------------
  // Longest form is four bytes, prefix included
  localparam int BUF_DEPTH = 4;
  bord_state_t state_q;
  bord_state_t state_d;
  logic [7:0] buf_q [0:BUF_DEPTH-1];
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;

  wire logic take = fetch_valid && fetch_ready;
  wire logic [7:0] nb0 = (cnt_q == 3'h0) ? fetch_byte : buf_q[0];
  wire logic [7:0] nb1 = (cnt_q == 3'h1) ? fetch_byte : buf_q[1];
  wire logic [7:0] nb2 = (cnt_q == 3'h2) ? fetch_byte : buf_q[2];
  wire logic [2:0] need_len;
  wire logic need_known;
  wire logic [2:0] cnt_inc = cnt_q + 3'h1;

  bord_len u_len (
    .b0(nb0),
    .b1(nb1),
    .b2(nb2),
    .len(need_len),
    .known(need_known)
  );

  // Length is only final once prefix and opcode bytes are in; before that
  // the byte view still shows bytes left over from the previous form
  wire logic two_byte_op = (nb0 == bord_pkg::OP_R_MEM) || (nb0 == bord_pkg::OP_MM)
    || (nb0 == bord_pkg::OP_PTR);
  wire logic [2:0] min_look = (nb0 == bord_pkg::OP_PREFIX_ALT) ? 3'h3
    : (two_byte_op ? 3'h2 : 3'h1);
  wire logic len_final = (cnt_inc >= min_look);
  wire logic done = take && len_final && (cnt_inc >= need_len); // RQ20

  assign fetch_ready = (state_q == BORD_ST_COLLECT);

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      BORD_ST_COLLECT:
      begin
        if (done)
        begin
          state_d = BORD_ST_ISSUE;
          cnt_d = cnt_inc;
        end
        else if (take)
        begin
          cnt_d = cnt_inc;
        end
      end
      BORD_ST_ISSUE:
      begin
        if (op_ready)
        begin
          state_d = BORD_ST_COLLECT;
          cnt_d = 3'h0;
        end
      end
      default:
      begin
        state_d = BORD_ST_COLLECT;
        cnt_d = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= BORD_ST_COLLECT;
      cnt_q <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < BUF_DEPTH; gi++)
    begin : g_buf
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
          buf_q[gi] <= 8'h00;
        else if (take && cnt_q == 3'(gi))
          buf_q[gi] <= fetch_byte;
      end
    end
  endgenerate

  // ----------------------------------------
  // Operand decode from next-byte view
  // ----------------------------------------
  wire logic [7:0] nb3 = (cnt_q == 3'h3) ? fetch_byte : buf_q[3];
  wire logic pfx = (nb0 == bord_pkg::OP_PREFIX_ALT);
  wire logic [7:0] o0 = pfx ? nb1 : nb0;
  wire logic [7:0] o1 = pfx ? nb2 : nb1;
  wire logic [7:0] o2 = pfx ? nb3 : nb2;
  wire logic [7:0] o3 = nb3;
  wire logic [7:0] reg_hi = {4'h0, o1[7:4]};
  wire logic [3:0] sub = o1[3:0];
  // Pointer space; the prefix moves the pointer into the alternate area
  wire logic [3:0] ptr_sp = o1[4]
    ? (pfx ? bord_pkg::BORD_SP_PTR24_SDA : bord_pkg::BORD_SP_PTR24_SDP)
    : (pfx ? bord_pkg::BORD_SP_PTR16_SDA : bord_pkg::BORD_SP_PTR16_SDP); // RQ17

  logic [3:0] dsp;
  logic [7:0] dsel;
  logic [3:0] ssp;
  logic [7:0] ssel;
  logic dwr;

  always_comb
  begin
    dsp = bord_pkg::BORD_SP_NONE;
    dsel = 8'h00;
    ssp = bord_pkg::BORD_SP_NONE;
    ssel = 8'h00;
    dwr = 1'b0;
    if (need_known)
    begin
      dwr = 1'b1; // RQ19
      if (o0 == bord_pkg::OP_RR)
      begin
        dsp = bord_pkg::BORD_SP_BASE_REG; // RQ1
        dsel = reg_hi;
        ssp = pfx ? bord_pkg::BORD_SP_EXT_REG : bord_pkg::BORD_SP_BASE_REG; // RQ2
        ssel = {5'h00, o1[2:0]};
      end
      else if (o0 == bord_pkg::OP_A_SDP)
      begin
        dsp = bord_pkg::BORD_SP_ACC; // RQ3
        ssp = bord_pkg::BORD_SP_SDP;
        ssel = o1;
      end
      else if (o0 == bord_pkg::OP_R_MEM)
      begin
        case (sub)
          bord_pkg::SUB_R_SDP:
          begin
            dsp = bord_pkg::BORD_SP_BASE_REG; // RQ4
            dsel = reg_hi;
            ssp = bord_pkg::BORD_SP_SDP;
            ssel = o2;
          end
          bord_pkg::SUB_R_SDA:
          begin
            dsp = bord_pkg::BORD_SP_BASE_REG; // RQ5
            dsel = reg_hi;
            ssp = bord_pkg::BORD_SP_SDA;
            ssel = o2;
          end
          bord_pkg::SUB_R_SFR:
          begin
            dsp = bord_pkg::BORD_SP_BASE_REG; // RQ8
            dsel = reg_hi;
            ssp = bord_pkg::BORD_SP_SFR;
            ssel = o2;
          end
          bord_pkg::SUB_SDP_R:
          begin
            dsp = bord_pkg::BORD_SP_SDP; // RQ6
            dsel = o2;
            ssp = bord_pkg::BORD_SP_BASE_REG;
            ssel = reg_hi;
          end
          bord_pkg::SUB_SDA_R:
          begin
            dsp = bord_pkg::BORD_SP_SDA; // RQ7
            dsel = o2;
            ssp = bord_pkg::BORD_SP_BASE_REG;
            ssel = reg_hi;
          end
          default:
          begin
            dsp = bord_pkg::BORD_SP_SFR; // RQ9
            dsel = o2;
            ssp = bord_pkg::BORD_SP_BASE_REG;
            ssel = reg_hi;
          end
        endcase
      end
      else if (o0 == bord_pkg::OP_MM)
      begin
        // Source offset in third byte, destination in fourth
        ssel = o2; // RQ10
        dsel = o3;
        ssp = o1[4] ? bord_pkg::BORD_SP_SDA : bord_pkg::BORD_SP_SDP; // RQ11 RQ13
        dsp = o1[5] ? bord_pkg::BORD_SP_SDA : bord_pkg::BORD_SP_SDP; // RQ12 RQ13
      end
      else
      begin
        // Pointer forms; prefix moves offset to fourth byte
        if (o1[7])
        begin
          dsp = ptr_sp; // RQ16 RQ18
          dsel = o2;
          ssp = bord_pkg::BORD_SP_ACC;
        end
        else
        begin
          dsp = bord_pkg::BORD_SP_ACC; // RQ14 RQ15
          ssp = ptr_sp;
          ssel = o2;
        end
      end
    end
  end

  // ----------------------------------------
  // Issue registers
  // ----------------------------------------
  // An unknown form retires with the bytes seen so far: a bad first byte
  // gives length one, a bad byte after a two-byte opcode gives more
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_dst_space <= 4'h0;
      op_dst_sel <= 8'h00;
      op_src_space <= 4'h0;
      op_src_sel <= 8'h00;
      op_dst_write <= 1'b0;
      op_length <= 3'h0;
      op_illegal <= 1'b0;
    end
    else if (done)
    begin
      op_dst_space <= dsp;
      op_dst_sel <= dsel;
      op_src_space <= ssp;
      op_src_sel <= ssel;
      op_dst_write <= dwr;
      op_length <= cnt_inc;
      op_illegal <= !need_known;
    end
  end

  assign op_src_write = 1'b0; // RQ19
  assign op_valid = (state_q == BORD_ST_ISSUE);

endmodule

`default_nettype wire

// *** hw/bord_len.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Instruction length from first bytes
// ----------------------------------------
module bord_len (
  // Leading bytes
  input wire logic [7:0] b0,
  input wire logic [7:0] b1,
  input wire logic [7:0] b2,
  // Result
  output logic [2:0] len,
  output logic known
);

  wire logic pfx = (b0 == bord_pkg::OP_PREFIX_ALT);
  wire logic [7:0] o0 = pfx ? b1 : b0;
  wire logic [7:0] o1 = pfx ? b2 : b1;
  wire logic [3:0] sub = o1[3:0];
  wire logic rmem_ok = (sub == bord_pkg::SUB_R_SDP) || (sub == bord_pkg::SUB_R_SDA)
    || (sub == bord_pkg::SUB_R_SFR) || (sub == bord_pkg::SUB_SDP_R)
    || (sub == bord_pkg::SUB_SDA_R) || (sub == bord_pkg::SUB_SFR_R);
  wire logic mm_ok = (o1 == bord_pkg::MM_PP) || (o1 == bord_pkg::MM_AP)
    || (o1 == bord_pkg::MM_PA) || (o1 == bord_pkg::MM_AA);
  wire logic ptr_ok = (o1 == bord_pkg::PTR_LD16) || (o1 == bord_pkg::PTR_LD24)
    || (o1 == bord_pkg::PTR_ST16) || (o1 == bord_pkg::PTR_ST24);

  always_comb
  begin
    len = 3'h1;
    known = 1'b0;
    if (!pfx && o0 == bord_pkg::OP_RR)
    begin
      len = 3'h2;
      known = 1'b1;
    end
    else if (pfx && o0 == bord_pkg::OP_RR)
    begin
      len = 3'h3;
      known = 1'b1;
    end
    else if (!pfx && o0 == bord_pkg::OP_A_SDP)
    begin
      len = 3'h2;
      known = 1'b1;
    end
    else if (!pfx && o0 == bord_pkg::OP_R_MEM && rmem_ok)
    begin
      len = 3'h3;
      known = 1'b1;
    end
    else if (!pfx && o0 == bord_pkg::OP_MM && mm_ok)
    begin
      len = 3'h4;
      known = 1'b1;
    end
    else if (o0 == bord_pkg::OP_PTR && ptr_ok)
    begin
      len = pfx ? 3'h4 : 3'h3;
      known = 1'b1;
    end
  end

endmodule

`default_nettype wire

// *** hw/bord_pkg.sv ***
package bord_pkg;

  // ----------------------------------------
  // Opcode bytes
  // ----------------------------------------
  localparam logic [7:0] OP_PREFIX_ALT = 8'h3C;
  localparam logic [7:0] OP_RR = 8'h8E;
  localparam logic [7:0] OP_A_SDP = 8'h9E;
  localparam logic [7:0] OP_R_MEM = 8'h7E;
  localparam logic [7:0] OP_MM = 8'h2A;
  localparam logic [7:0] OP_PTR = 8'h07;
  localparam logic [7:0] MM_PP = 8'h0E;
  localparam logic [7:0] MM_AP = 8'h1E;
  localparam logic [7:0] MM_PA = 8'h2E;
  localparam logic [7:0] MM_AA = 8'h3E;
  localparam logic [7:0] PTR_LD16 = 8'h2E;
  localparam logic [7:0] PTR_LD24 = 8'h3E;
  localparam logic [7:0] PTR_ST16 = 8'hAE;
  localparam logic [7:0] PTR_ST24 = 8'hBE;
  localparam logic [3:0] SUB_R_SDP = 4'h0;
  localparam logic [3:0] SUB_R_SDA = 4'h1;
  localparam logic [3:0] SUB_R_SFR = 4'h2;
  localparam logic [3:0] SUB_SDP_R = 4'h4;
  localparam logic [3:0] SUB_SDA_R = 4'h5;
  localparam logic [3:0] SUB_SFR_R = 4'h6;

  // ----------------------------------------
  // Operand space codes
  // ----------------------------------------
  typedef enum logic [3:0] {
    BORD_SP_NONE = 4'h0,
    BORD_SP_BASE_REG = 4'h1,
    BORD_SP_EXT_REG = 4'h2,
    BORD_SP_ACC = 4'h3,
    BORD_SP_SDP = 4'h4,
    BORD_SP_SDA = 4'h5,
    BORD_SP_SFR = 4'h6,
    BORD_SP_PTR16_SDP = 4'h7,
    BORD_SP_PTR16_SDA = 4'h8,
    BORD_SP_PTR24_SDP = 4'h9,
    BORD_SP_PTR24_SDA = 4'hA
  } bord_space_t;

  localparam logic [2:0] MAX_LEN = 3'h5;

endpackage
